//--- design/sfc_chan.sv
// One FIFO channel with its pin-level write and read ports and an AXI4-Lite
// register slave for the flag offsets, a soft reset and status.
// Assumes all pins, including both port clocks, are synchronous to aclk and
// that each port clock stays high or low for at least one aclk period.
`timescale 1ns/1ps
`include "sfc_cfg.svh"

module sfc_chan
  import sfc_pkg::*;
#(
  parameter int DW    = 9,    // Data word width
  parameter int DEPTH = 256   // Channel depth in words
) (
  input  wire logic          aclk,                            // System clock
  input  wire logic          aresetn,                         // Synchronous reset, active low
  // Register bus
  input  wire logic [11:0]   s_axi_awaddr,                    // Write address
  input  wire logic [2:0]    s_axi_awprot,                    // Write protection, unused
  input  wire logic          s_axi_awvalid,                   // Write address valid
  output logic               s_axi_awready,                   // Write address ready
  input  wire logic [31:0]   s_axi_wdata,                     // Write data
  input  wire logic [3:0]    s_axi_wstrb,                     // Write byte strobes
  input  wire logic          s_axi_wvalid,                    // Write data valid
  output logic               s_axi_wready,                    // Write data ready
  output logic [1:0]         s_axi_bresp,                     // Write response
  output logic               s_axi_bvalid,                    // Write response valid
  input  wire logic          s_axi_bready,                    // Write response ready
  input  wire logic [11:0]   s_axi_araddr,                    // Read address
  input  wire logic [2:0]    s_axi_arprot,                    // Read protection, unused
  input  wire logic          s_axi_arvalid,                   // Read address valid
  output logic               s_axi_arready,                   // Read address ready
  output logic [31:0]        s_axi_rdata,                     // Read data
  output logic [1:0]         s_axi_rresp,                     // Read response
  output logic               s_axi_rvalid,                    // Read data valid
  input  wire logic          s_axi_rready,                    // Read data ready
  // Channel pins
  input  wire logic          fifo_reset_n,                    // Channel reset pin, active low
  input  wire logic          write_clock,                     // Write port clock pin
  input  wire logic          write_enable_primary_n,          // Primary write enable, active low
  input  wire logic          write_enable_secondary_or_load,  // Second enable or offset load
  input  wire logic [DW-1:0] write_data_in,                   // Input word
  input  wire logic          read_clock,                      // Read port clock pin
  input  wire logic          read_enable_first_n,             // First read enable, active low
  input  wire logic          read_enable_second_n,            // Second read enable, active low
  input  wire logic          output_drive_enable_n,           // Output enable, active low
  output logic [DW-1:0]      read_data_out,                   // Output word
  output logic               read_data_oe,                    // High while driving read_data_out
  output logic               empty_flag_n,                    // Empty, active low
  output logic               almost_empty_flag_n,             // Almost empty, active low
  output logic               almost_full_flag_n,              // Almost full, active low
  output logic               full_flag_n                      // Full, active low
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  // --------------------------------------------------------------------------
  // Channel state
  // --------------------------------------------------------------------------
  logic          chan_rst;
  logic          soft_rst_r;
  sfc_mode_t     mode_r;
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] ae_off_r;
  logic [CW-1:0] af_off_r;
  logic          wr_ofs_sel_r;
  logic          rd_ofs_sel_r;
  logic          empty_n_r;
  logic          ae_n_r;
  logic          af_n_r;
  logic          full_n_r;
  logic [DW-1:0] rd_data_r;
  logic          oe_r;
  logic          wr_rise;
  logic          rd_rise;
  logic          load_active;
  logic          wr_do;
  logic          rd_do;
  logic          ofs_wr;
  logic          ofs_rd;
  logic [DW-1:0] mem_q;

  // Pin reset, bus reset and the software reset all rewind the channel
  assign chan_rst = !aresetn || !fifo_reset_n || soft_rst_r;

  sfc_edge u_wr_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (write_clock),
    .rise    (wr_rise)
  );

  sfc_edge u_rd_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (read_clock),
    .rise    (rd_rise)
  );

  // --------------------------------------------------------------------------
  // Port qualification
  // --------------------------------------------------------------------------
  assign load_active = (mode_r == SFC_MODE_PROG) && !write_enable_secondary_or_load;

  // Same term serves both modes: in offset mode a high load pin means a plain write
  assign wr_do = wr_rise && !write_enable_primary_n && write_enable_secondary_or_load
                 && full_n_r && (cnt_r != FULL_CNT);
  assign ofs_wr = wr_rise && !write_enable_primary_n && load_active;
  assign rd_do = rd_rise && !read_enable_first_n && !read_enable_second_n && !load_active
                 && empty_n_r && (cnt_r != '0);
  assign ofs_rd = rd_rise && !read_enable_first_n && !read_enable_second_n && load_active;

  always_comb begin
    cnt_nxt = cnt_r;
    if (wr_do && !rd_do) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (rd_do && !wr_do) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Mode strap
  // --------------------------------------------------------------------------
  // Caught on every clock of reset, so the level seen last before release holds
  always_ff @(posedge aclk) begin
    if (chan_rst) begin
      mode_r <= write_enable_secondary_or_load ? SFC_MODE_DUAL_WE : SFC_MODE_PROG;
    end
  end

  // --------------------------------------------------------------------------
  // Pointers and fill count
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (chan_rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end else begin
      if (wr_do) begin
        wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
      end
      if (rd_do) begin
        rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
    end
  end

  sfc_mem #(
    .DW    (DW),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .aclk  (aclk),
    .we    (wr_do),
    .waddr (wptr_r),
    .wdata (write_data_in),
    .raddr (rptr_r),
    .rdata (mem_q)
  );

  // --------------------------------------------------------------------------
  // Flags
  // --------------------------------------------------------------------------
  // Each flag moves only on its own port clock, so it can lag the count
  always_ff @(posedge aclk) begin
    if (chan_rst) begin
      full_n_r <= 1'b1;
      af_n_r   <= 1'b1;
    end else if (wr_rise) begin
      full_n_r <= (cnt_nxt != FULL_CNT);
      af_n_r   <= !(cnt_nxt >= FULL_CNT - af_off_r);
    end
  end

  always_ff @(posedge aclk) begin
    if (chan_rst) begin
      empty_n_r <= 1'b0;
      ae_n_r    <= 1'b0;
    end else if (rd_rise) begin
      empty_n_r <= (cnt_nxt != '0);
      ae_n_r    <= (cnt_nxt > ae_off_r);
    end
  end

  // --------------------------------------------------------------------------
  // Read data and output enable
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (chan_rst) begin
      rd_data_r    <= '0;
      rd_ofs_sel_r <= 1'b0;
    end else if (rd_do) begin
      rd_data_r <= mem_q;
    end else if (ofs_rd) begin
      rd_data_r    <= rd_ofs_sel_r ? DW'(af_off_r) : DW'(ae_off_r);
      rd_ofs_sel_r <= !rd_ofs_sel_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= !output_drive_enable_n;
    end
  end

  assign read_data_out       = rd_data_r;
  assign read_data_oe        = oe_r;
  assign empty_flag_n        = empty_n_r;
  assign almost_empty_flag_n = ae_n_r;
  assign almost_full_flag_n  = af_n_r;
  assign full_flag_n         = full_n_r;

  // --------------------------------------------------------------------------
  // Register bus: write channel
  // --------------------------------------------------------------------------
  sfc_wr_state_t wst_r;
  logic          aw_got_r;
  logic          w_got_r;
  logic [11:0]   awaddr_r;
  logic [31:0]   wdata_r;
  logic [3:0]    wstrb_r;
  logic          awready_r;
  logic          wready_r;
  logic          bvalid_r;
  logic [1:0]    bresp_r;
  logic          bus_wr;

  function automatic logic reg_known(input logic [11:0] a);
    reg_known = (a == `SFC_OFS_CTRL) || (a == `SFC_OFS_AE_OFFSET)
                || (a == `SFC_OFS_AF_OFFSET) || (a == `SFC_OFS_STATUS);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r     <= SFC_WR_IDLE;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `SFC_RESP_OKAY;
    end else begin
      unique case (wst_r)
        SFC_WR_IDLE: begin
          awready_r <= !aw_got_r && !(s_axi_awvalid && awready_r);
          wready_r  <= !w_got_r && !(s_axi_wvalid && wready_r);
          if (s_axi_awvalid && awready_r) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
          end
          if (s_axi_wvalid && wready_r) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
          end
          if ((aw_got_r || (s_axi_awvalid && awready_r)) && (w_got_r || (s_axi_wvalid && wready_r))) begin
            wst_r     <= SFC_WR_EXEC;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
          end
        end
        SFC_WR_EXEC: begin
          aw_got_r <= 1'b0;
          w_got_r  <= 1'b0;
          bvalid_r <= 1'b1;
          bresp_r  <= reg_known(awaddr_r) && (awaddr_r != `SFC_OFS_STATUS) ? `SFC_RESP_OKAY : `SFC_RESP_SLVERR;
          wst_r    <= SFC_WR_RESP;
        end
        SFC_WR_RESP: begin
          if (s_axi_bready) begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            wst_r     <= SFC_WR_IDLE;
          end
        end
      endcase
    end
  end

  assign bus_wr = (wst_r == SFC_WR_EXEC) && wstrb_r[0];

  // --------------------------------------------------------------------------
  // Control and offset registers
  // --------------------------------------------------------------------------
  // Soft reset is a single-cycle pulse, so it cannot wedge the channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= bus_wr && (awaddr_r == `SFC_OFS_CTRL) && wdata_r[`SFC_CTRL_SOFT_RST];
    end
  end

  // A pin load wins over a bus write landing in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || !fifo_reset_n) begin
      ae_off_r     <= CW'(`SFC_AE_OFFSET_RST);
      af_off_r     <= CW'(`SFC_AF_OFFSET_RST);
      wr_ofs_sel_r <= 1'b0;
    end else if (ofs_wr) begin
      if (wr_ofs_sel_r) begin
        af_off_r <= CW'(write_data_in);
      end else begin
        ae_off_r <= CW'(write_data_in);
      end
      wr_ofs_sel_r <= !wr_ofs_sel_r;
    end else if (bus_wr && (awaddr_r == `SFC_OFS_AE_OFFSET)) begin
      ae_off_r <= wdata_r[CW-1:0];
    end else if (bus_wr && (awaddr_r == `SFC_OFS_AF_OFFSET)) begin
      af_off_r <= wdata_r[CW-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Register bus: read channel
  // --------------------------------------------------------------------------
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] status_w;

  always_comb begin
    status_w = '0;
    status_w[`SFC_ST_COUNT_LSB +: CW] = cnt_r;
    status_w[`SFC_ST_EMPTY_N]         = empty_n_r;
    status_w[`SFC_ST_AE_N]            = ae_n_r;
    status_w[`SFC_ST_AF_N]            = af_n_r;
    status_w[`SFC_ST_FULL_N]          = full_n_r;
    status_w[`SFC_ST_PROG_MODE]       = (mode_r == SFC_MODE_PROG);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= `SFC_RESP_OKAY;
    end else if (rvalid_r) begin
      if (s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= reg_known(s_axi_araddr) ? `SFC_RESP_OKAY : `SFC_RESP_SLVERR;
      unique case (s_axi_araddr)
        `SFC_OFS_AE_OFFSET: rdata_r <= 32'(ae_off_r);
        `SFC_OFS_AF_OFFSET: rdata_r <= 32'(af_off_r);
        `SFC_OFS_STATUS:    rdata_r <= status_w;
        default:            rdata_r <= '0;
      endcase
    end else begin
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

endmodule

//--- design/sfc_edge.sv
// Rising edge detector for a pin-level clock sampled by aclk.
// Assumes the pin is already synchronous to aclk.
`timescale 1ns/1ps

module sfc_edge (
  input  wire logic aclk,     // System clock
  input  wire logic aresetn,  // Synchronous reset, active low
  input  wire logic pin,      // Sampled clock pin
  output logic      rise      // One-cycle pulse on a low-to-high change
);

  logic prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= pin;
    end
  end

  // Prev resets high so a pin already high at reset is not seen as an edge
  assign rise = pin & ~prev_r;

endmodule

//--- design/sfc_mem.sv
// Storage array of one FIFO channel: one write port, one asynchronous read port.
// Assumes the controller never writes and reads one location with stale data.
`timescale 1ns/1ps

module sfc_mem #(
  parameter int DW    = 9,    // Word width
  parameter int DEPTH = 256,  // Words
  parameter int AW    = 8     // Address width
) (
  input  wire logic          aclk,   // System clock
  input  wire logic          we,     // Write strobe
  input  wire logic [AW-1:0] waddr,  // Write address
  input  wire logic [DW-1:0] wdata,  // Write data
  input  wire logic [AW-1:0] raddr,  // Read address
  output logic      [DW-1:0] rdata   // Read data
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];

endmodule

//--- dv/sfc_chan_properties.sv
// Pin-level checker for one FIFO channel, bound into sfc_chan.
// Assumes every pin, port clocks included, is sampled on aclk.
`timescale 1ns/1ps

module sfc_chan_properties #(
  parameter int DW    = 9,   // Word width
  parameter int DEPTH = 256  // Channel depth
) (
  input wire logic          aclk, // System clock
  input wire logic          aresetn, // Reset, active low
  input wire logic          fifo_reset_n, // Channel reset
  input wire logic          write_clock, // Write port clock
  input wire logic          write_enable_secondary_or_load, // Shared pin
  input wire logic          read_clock, // Read port clock
  input wire logic          output_drive_enable_n, // Output enable
  input wire logic [DW-1:0] read_data_out, // Output word
  input wire logic          read_data_oe, // Output drive
  input wire logic          empty_flag_n, // Empty
  input wire logic          almost_empty_flag_n, // Almost empty
  input wire logic          almost_full_flag_n, // Almost full
  input wire logic          full_flag_n // Full
);
  // ---------------------------------------------------------------------------
  // Port events
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Flags are stale between port edges, so only an edge may move them
  sequence s_wr_quiet; fifo_reset_n && !(write_clock && !$past(write_clock)); endsequence
  sequence s_rd_quiet; fifo_reset_n && !(read_clock && !$past(read_clock)); endsequence
  sequence s_rd_rise; fifo_reset_n && read_clock && !$past(read_clock); endsequence

  property p_reset_state;
    !fifo_reset_n |=> full_flag_n && almost_full_flag_n && !empty_flag_n && !almost_empty_flag_n && read_data_out == '0;
  endproperty
  property p_oe_follow; 1'b1 |=> read_data_oe == !$past(output_drive_enable_n); endproperty
  property p_empty_hold; s_rd_quiet |=> $stable(empty_flag_n); endproperty
  property p_ae_hold; s_rd_quiet |=> $stable(almost_empty_flag_n); endproperty
  property p_full_hold; s_wr_quiet |=> $stable(full_flag_n); endproperty
  property p_af_hold; s_wr_quiet |=> $stable(almost_full_flag_n); endproperty
  property p_rd_hold; s_rd_quiet |=> $stable(read_data_out); endproperty
  property p_empty_blocks;
    s_rd_rise ##0 (!empty_flag_n && write_enable_secondary_or_load) |=> $stable(read_data_out);
  endproperty
  property p_full_af; !full_flag_n |-> !almost_full_flag_n; endproperty
  property p_empty_ae; !empty_flag_n |-> !almost_empty_flag_n; endproperty

  a_reset_state: assert property (p_reset_state) else $error("reset state");
  a_oe_follow: assert property (p_oe_follow) else $error("oe");
  a_empty_hold: assert property (p_empty_hold) else $error("empty moved");
  a_ae_hold: assert property (p_ae_hold) else $error("ae moved");
  a_full_hold: assert property (p_full_hold) else $error("full moved");
  a_af_hold: assert property (p_af_hold) else $error("af moved");
  a_rd_hold: assert property (p_rd_hold) else $error("word moved");
  a_empty_blocks: assert property (p_empty_blocks) else $error("empty read");
  a_full_af: assert property (p_full_af) else $error("full not af");
  a_empty_ae: assert property (p_empty_ae) else $error("empty not ae");
endmodule

bind sfc_chan sfc_chan_properties #(.DW(DW), .DEPTH(DEPTH)) sfc_chan_properties_inst (.*);

//--- dv/sfc_host.sv
// Host pin model: drives the channel reset, write port and read port.
// Assumes its tasks are entered just after a rising aclk edge.
`timescale 1ns/1ps

module sfc_host #(
  parameter int DW = 9  // Word width
) (
  input  wire logic     aclk, // System clock
  output logic          fifo_reset_n, // Channel reset
  output logic          write_clock, // Write port clock
  output logic          write_enable_primary_n, // Primary enable
  output logic          write_enable_secondary_or_load, // Shared pin
  output logic [DW-1:0] write_data_in, // Input word
  output logic          read_clock, // Read port clock
  output logic          read_enable_first_n, // Read enable 1
  output logic          read_enable_second_n // Read enable 2
);
  initial begin
    {fifo_reset_n, write_clock, write_enable_primary_n, write_enable_secondary_or_load} = 4'b1011;
    {write_data_in, read_clock, read_enable_first_n, read_enable_second_n} = 12'h003;
  end

  // The strap level is what the channel latches while reset is low
  task automatic chan_reset(input logic strap);
    write_enable_secondary_or_load <= strap;
    fifo_reset_n <= 1'b0;
    repeat (3) @(posedge aclk);
    fifo_reset_n <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic wr(input logic pri_n, sec, input logic [DW-1:0] d);
    write_enable_primary_n <= pri_n;
    write_enable_secondary_or_load <= sec;
    write_data_in <= d;
    write_clock <= 1'b1;
    repeat (2) @(posedge aclk);
    write_clock <= 1'b0;
    write_enable_primary_n <= 1'b1;
    // Released bus shows the inverse so a stale copy is never taken
    write_data_in <= ~d;
    repeat (2) @(posedge aclk);
  endtask

  task automatic rd(input logic e1_n, e2_n);
    read_enable_first_n <= e1_n;
    read_enable_second_n <= e2_n;
    read_clock <= 1'b1;
    repeat (2) @(posedge aclk);
    read_clock <= 1'b0;
    read_enable_first_n <= 1'b1;
    read_enable_second_n <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
endmodule

//--- dv/tb_sfc_chan.sv
// Self-checking bench for sfc_chan with a small depth.
// Assumes sfc_cfg.svh on the include path and sfc_host as the pin partner.
`timescale 1ns/1ps
`include "sfc_cfg.svh"

module tb_sfc_chan
  import sfc_pkg::*;
;
  localparam int DEPTH = 16;
  logic        aclk, aresetn, output_drive_enable_n, read_data_oe;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        fifo_reset_n, write_clock, write_enable_primary_n, write_enable_secondary_or_load;
  logic        read_clock, read_enable_first_n, read_enable_second_n;
  logic [8:0]  write_data_in, read_data_out, d;
  logic        empty_flag_n, almost_empty_flag_n, almost_full_flag_n, full_flag_n;
  logic [8:0]  q[$];
  int          failures, check_count, seed, i;

  sfc_chan #(.DW(9), .DEPTH(DEPTH)) sfc_chan_inst (.*);
  sfc_host #(.DW(9)) sfc_host_inst (.*);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  function automatic logic exp_ae(input int cnt, input int off);
    return cnt > off;
  endfunction
  function automatic logic exp_af(input int cnt, input int off);
    return !(cnt >= DEPTH - off);
  endfunction

  task automatic chk(input logic [31:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] wd);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    complete_run;
  end

  initial begin
    seed = 60716;
    aresetn = 1'b0;
    output_drive_enable_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00f;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    sfc_host_inst.chan_reset(1'b1);
    chk({empty_flag_n, almost_empty_flag_n, almost_full_flag_n, full_flag_n}, 4'b0011, "rst");
    axi_rd(`SFC_OFS_AE_OFFSET);
    chk(rd, 7, "aeo");
    axi_rd(`SFC_OFS_AF_OFFSET);
    chk(rd, 7, "afo");
    axi_rd(`SFC_OFS_STATUS);
    chk(rd[`SFC_ST_PROG_MODE], 0, "dual");
    axi_rd(12'h010);
    chk(rsp, `SFC_RESP_SLVERR, "unmap");
    axi_wr(`SFC_OFS_STATUS, 32'h0);
    chk(rsp, `SFC_RESP_SLVERR, "stw");
    sfc_host_inst.wr(1'b0, 1'b0, 9'h1aa);
    sfc_host_inst.wr(1'b1, 1'b1, 9'h155);
    // One write past full must be dropped
    for (i = 0; i <= DEPTH; i++) begin
      d = $random(seed);
      sfc_host_inst.wr(1'b0, 1'b1, d);
      if (i < DEPTH) q.push_back(d);
      chk(full_flag_n, q.size() < DEPTH, "full");
      chk(almost_full_flag_n, exp_af(q.size(), 7), "af");
    end
    axi_rd(`SFC_OFS_STATUS);
    chk(rd[8:0], DEPTH, "count");
    chk(empty_flag_n, 0, "stale");
    sfc_host_inst.rd(1'b0, 1'b0);
    chk(read_data_out, 0, "rd empty");
    sfc_host_inst.rd(1'b1, 1'b0);
    sfc_host_inst.rd(1'b0, 1'b1);
    chk(read_data_out, 0, "one en");
    while (q.size() > 0) begin
      sfc_host_inst.rd(1'b0, 1'b0);
      chk(read_data_out, q.pop_front(), "data");
      chk(almost_empty_flag_n, exp_ae(q.size(), 7), "ae");
    end
    chk(empty_flag_n, 0, "drained");
    output_drive_enable_n <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(read_data_oe, 0, "oe off");
    output_drive_enable_n <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(read_data_oe, 1, "oe on");
    sfc_host_inst.chan_reset(1'b0);
    axi_rd(`SFC_OFS_STATUS);
    chk(rd[`SFC_ST_PROG_MODE], 1, "prog");
    sfc_host_inst.wr(1'b0, 1'b0, 9'h003);
    sfc_host_inst.wr(1'b0, 1'b0, 9'h002);
    axi_rd(`SFC_OFS_AE_OFFSET);
    chk(rd, 3, "ae ld");
    axi_rd(`SFC_OFS_AF_OFFSET);
    chk(rd, 2, "af ld");
    sfc_host_inst.rd(1'b0, 1'b0);
    chk(read_data_out, 3, "ae rb");
    sfc_host_inst.rd(1'b0, 1'b0);
    chk(read_data_out, 2, "af rb");
    axi_wr(`SFC_OFS_AE_OFFSET, 32'h5);
    chk(rsp, `SFC_RESP_OKAY, "ae wr");
    // No strobe: offset must stay 5, else the flag check below trips
    s_axi_wstrb <= 4'h0;
    axi_wr(`SFC_OFS_AE_OFFSET, 32'h9);
    for (i = 0; i < 6; i++) begin
      d = $random(seed);
      sfc_host_inst.wr(1'b0, 1'b1, d);
      q.push_back(d);
    end
    sfc_host_inst.rd(1'b0, 1'b0);
    chk(read_data_out, 2, "refused");
    chk(almost_empty_flag_n, exp_ae(6, 5), "ae prog");
    while (q.size() > 0) begin
      sfc_host_inst.rd(1'b0, 1'b0);
      chk(read_data_out, q.pop_front(), "pdata");
    end
    complete_run;
  end
endmodule

//--- include/sfc_cfg.svh
// Constants for the synchronous FIFO channel port control: register offsets,
// field positions, reset values and bus response codes.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SFC_OFS_CTRL       12'h000
`define SFC_OFS_AE_OFFSET  12'h004
`define SFC_OFS_AF_OFFSET  12'h008
`define SFC_OFS_STATUS     12'h00c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SFC_CTRL_SOFT_RST  0
`define SFC_ST_COUNT_LSB   0
`define SFC_ST_EMPTY_N     16
`define SFC_ST_AE_N        17
`define SFC_ST_AF_N        18
`define SFC_ST_FULL_N      19
`define SFC_ST_PROG_MODE   20

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SFC_AE_OFFSET_RST  7
`define SFC_AF_OFFSET_RST  7

// ----------------------------------------------------------------------------
// AXI4-Lite responses
// ----------------------------------------------------------------------------
`define SFC_RESP_OKAY      2'h0
`define SFC_RESP_SLVERR    2'h2

`endif

//--- include/sfc_pkg.sv
// Types shared by the FIFO channel port control design.
// Assumes sfc_cfg.svh sits on the include path.
`include "sfc_cfg.svh"

package sfc_pkg;

  // Write-port configuration latched at reset
  typedef enum logic [1:0] {
    SFC_MODE_DUAL_WE = 2'b01,
    SFC_MODE_PROG    = 2'b10
  } sfc_mode_t;

  // Register bus write channel state
  typedef enum logic [2:0] {
    SFC_WR_IDLE = 3'b001,
    SFC_WR_EXEC = 3'b010,
    SFC_WR_RESP = 3'b100
  } sfc_wr_state_t;

endpackage
